/* verilog/cdmb_defines.svh */
// offsets, field positions, reset values and fixed register indices for the data-move core
`ifndef CDMB_DEFINES_SVH
`define CDMB_DEFINES_SVH

// ------------------------------------------------------------
// software register map (8-bit byte offsets)
// ------------------------------------------------------------
`define CDMB_SW_GPR_LAST   8'h1F
`define CDMB_SW_STATUS     8'h20
`define CDMB_SW_EXT_PAGE   8'h21
`define CDMB_SW_PC_LO      8'h22
`define CDMB_SW_PC_HI      8'h23
`define CDMB_SW_SP_LO      8'h24
`define CDMB_SW_SP_HI      8'h25
`define CDMB_SW_CORE_STATE 8'h26

// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define CDMB_FLAG_C 3'd0
`define CDMB_FLAG_Z 3'd1
`define CDMB_FLAG_N 3'd2
`define CDMB_FLAG_V 3'd3
`define CDMB_FLAG_S 3'd4
`define CDMB_FLAG_H 3'd5
`define CDMB_FLAG_T 3'd6
`define CDMB_FLAG_I 3'd7

// ------------------------------------------------------------
// reset values and fixed register indices
// ------------------------------------------------------------
`define CDMB_STATUS_RST   8'h00
`define CDMB_EXT_PAGE_RST 8'h00
`define CDMB_PC_RST       16'h0000
`define CDMB_SP_RST       16'h0FFF
`define CDMB_PTR_X_BASE   5'd26
`define CDMB_R0           5'd0
`define CDMB_R1           5'd1
`define CDMB_ONE16        16'h0001
`define CDMB_ONE24        24'h00_0001

`endif

/* verilog/cdmb_pkg.sv */
// types shared by the data-move core
package cdmb_pkg;

  // ------------------------------------------------------------
  // operations presented on the op port
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_MOV, OP_COPY_PAIR, OP_LDI,
    OP_LD, OP_LOAD_DIRECT, OP_ST, OP_STORE_DIRECT, OP_CODE_READ, OP_EXT_CODE_READ,
    OP_CODE_WRITE, OP_IN, OP_OUT, OP_PUSH, OP_POP, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_SIGN_SHIFT_R, OP_SWAP, OP_STATUS_SET,
    OP_STATUS_CLR, OP_TO_TFLAG, OP_FROM_TFLAG, OP_IRQ_ON, OP_IRQ_OFF
  } cdmb_op_e;

  // pointer addressing form for indirect load and store
  typedef enum logic [1:0] {
    PTR_PLAIN    = 2'd0,
    PTR_POST_INC = 2'd1,
    PTR_PRE_DEC  = 2'd2,
    PTR_DISP     = 2'd3
  } cdmb_ptr_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_PM   = 5'b01000,
    ST_IO   = 5'b10000
  } cdmb_state_e;

  typedef struct packed {
    cdmb_state_e     state;
    logic [31:0][7:0] gpr;
    logic [7:0]      status_register;
    logic [7:0]      ext_page;
    logic [15:0]     pc;
    logic [15:0]     sp;
    logic [4:0]      dst;
    logic [5:0]      io_addr;
    logic [7:0]      io_val;
    logic [2:0]      bit_sel;
    logic            bit_set;
    logic [7:0]      sw_rdata;
  } cdmb_s;

endpackage

/* verilog/cdmb_core.sv */
// execution core for data moves, bit operations, shifts and flag operations
// Notes on behaviour
// - branch on interrupt flag, target pc+k+1
// - register and pair copies, one cycle, flags kept
// - pointer loads two cycles, post-inc, pre-dec
// - second/third pointer loads with displacement
// - direct load from instruction address, two cycles
// - pointer stores plain, post-inc, pre-dec, two cycles
// - second/third pointer stores with displacement
// - direct store to instruction address, two cycles
// - code read at third pointer, three cycles
// - extended code read uses page above pointer
// - code write of r1:r0, one cycle
// - push register onto stack, two cycles
// - pop stack into register, two cycles
// - set or clear one io bit, two cycles
// - shifts and rotates update Z C N V
// - sign keeping shift holds bit seven
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - set or clear any single status flag
// - global interrupt enable and disable
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "cdmb_defines.svh"

module cdmb_core (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET_N,
  input  wire logic                    OP_VALID,
  output logic                         OP_READY,
  input  wire cdmb_pkg::cdmb_op_e      OP_CODE,
  input  wire logic [4:0]              OP_DST,
  input  wire logic [4:0]              OP_SRC,
  input  wire logic [2:0]              OP_BIT,
  input  wire logic [1:0]              OP_PTR,
  input  wire cdmb_pkg::cdmb_ptr_mode_e OP_MODE,
  input  wire logic [15:0]             OP_IMM,
  output logic [15:0]                  DM_ADDR,
  output logic                         DM_RE,
  output logic                         DM_WE,
  output logic [7:0]                   DM_WDATA,
  input  wire logic [7:0]              DM_RDATA,
  output logic [23:0]                  PM_ADDR,
  output logic                         PM_RE,
  output logic                         PM_WE,
  output logic [15:0]                  PM_WDATA,
  input  wire logic [7:0]              PM_RDATA,
  output logic [5:0]                   IO_ADDR,
  output logic                         IO_RE,
  output logic                         IO_WE,
  output logic [7:0]                   IO_WDATA,
  input  wire logic [7:0]              IO_RDATA,
  output logic [15:0]                  PC,
  output logic [7:0]                   STATUS,
  input  wire logic [7:0]              SW_ADDR,
  input  wire logic [7:0]              SW_WDATA,
  input  wire logic                    SW_WR,
  input  wire logic                    SW_RD,
  output logic [7:0]                   SW_RDATA
);
  import cdmb_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    ptr_base = `CDMB_PTR_X_BASE + {2'b00, sel, 1'b0};
  endfunction

  function automatic logic [15:0] ptr_get(input logic [31:0][7:0] g,
                                          input logic [1:0] sel);
    logic [4:0] b;
    b = ptr_base(sel);
    ptr_get = {g[b + 5'd1], g[b]};
  endfunction

  function automatic logic [7:0] shift_flags(input logic [7:0] s,
                                             input logic [7:0] res,
                                             input logic       c);
    logic [7:0] f;
    f = s;
    f[`CDMB_FLAG_C] = c;
    f[`CDMB_FLAG_Z] = (res == 8'h00);
    f[`CDMB_FLAG_N] = res[7];
    f[`CDMB_FLAG_V] = res[7] ^ c;
    shift_flags = f;
  endfunction

  cdmb_s r_reg;
  cdmb_s r_next;

  // ------------------------------------------------------------
  // next state and memory strobes
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] p;
    logic [15:0] addr;
    logic [15:0] np;
    logic [4:0]  pb;
    logic [7:0]  d;
    logic [7:0]  res;
    logic        c;
    logic [23:0] full;
    p        = 16'h0000;
    addr     = 16'h0000;
    np       = 16'h0000;
    pb       = 5'd0;
    d        = 8'h00;
    res      = 8'h00;
    c        = 1'b0;
    full     = 24'h00_0000;
    r_next   = r_reg;
    DM_ADDR  = 16'h0000;
    DM_RE    = 1'b0;
    DM_WE    = 1'b0;
    DM_WDATA = 8'h00;
    PM_ADDR  = 24'h00_0000;
    PM_RE    = 1'b0;
    PM_WE    = 1'b0;
    PM_WDATA = 16'h0000;
    IO_ADDR  = 6'd0;
    IO_RE    = 1'b0;
    IO_WE    = 1'b0;
    IO_WDATA = 8'h00;
    OP_READY = (r_reg.state == ST_IDLE);

    unique case (r_reg.state)
      ST_IDLE: begin
        if (OP_VALID) begin
          r_next.pc = r_reg.pc + `CDMB_ONE16;
          pb = ptr_base(OP_PTR);
          p  = ptr_get(r_reg.gpr, OP_PTR);
          d  = r_reg.gpr[OP_DST];
          // pointer forms: address used and pointer written back
          unique case (OP_MODE)
            PTR_POST_INC: begin
              addr = p;
              np   = p + `CDMB_ONE16;
            end
            PTR_PRE_DEC: begin
              addr = p - `CDMB_ONE16;
              np   = addr;
            end
            PTR_DISP: begin
              addr = p + OP_IMM;
              np   = p;
            end
            default: begin
              addr = p;
              np   = p;
            end
          endcase
          unique case (OP_CODE)
            OP_BR_IRQ_ON, OP_BR_IRQ_OFF: begin
              // taken branch spends its second cycle in wait
              if (r_reg.status_register[`CDMB_FLAG_I] == (OP_CODE == OP_BR_IRQ_ON)) begin
                r_next.pc    = r_reg.pc + OP_IMM + `CDMB_ONE16;
                r_next.state = ST_WAIT;
              end
            end
            OP_MOV:  r_next.gpr[OP_DST] = r_reg.gpr[OP_SRC];
            OP_COPY_PAIR: begin
              r_next.gpr[{OP_DST[4:1], 1'b0}] = r_reg.gpr[{OP_SRC[4:1], 1'b0}];
              r_next.gpr[{OP_DST[4:1], 1'b1}] = r_reg.gpr[{OP_SRC[4:1], 1'b1}];
            end
            OP_LDI:  r_next.gpr[OP_DST] = OP_IMM[7:0];
            OP_LD: begin
              DM_ADDR = addr;
              DM_RE   = 1'b1;
              r_next.gpr[pb]          = np[7:0];
              r_next.gpr[pb + 5'd1]   = np[15:8];
              r_next.dst   = OP_DST;
              r_next.state = ST_LOAD;
            end
            OP_LOAD_DIRECT: begin
              DM_ADDR      = OP_IMM;
              DM_RE        = 1'b1;
              r_next.pc    = r_reg.pc + 16'h0002;
              r_next.dst   = OP_DST;
              r_next.state = ST_LOAD;
            end
            OP_ST: begin
              DM_ADDR  = addr;
              DM_WE    = 1'b1;
              DM_WDATA = r_reg.gpr[OP_SRC];
              r_next.gpr[pb]        = np[7:0];
              r_next.gpr[pb + 5'd1] = np[15:8];
              r_next.state = ST_WAIT;
            end
            OP_STORE_DIRECT: begin
              DM_ADDR      = OP_IMM;
              DM_WE        = 1'b1;
              DM_WDATA     = r_reg.gpr[OP_SRC];
              r_next.pc    = r_reg.pc + 16'h0002;
              r_next.state = ST_WAIT;
            end
            OP_CODE_READ, OP_EXT_CODE_READ: begin
              p = ptr_get(r_reg.gpr, 2'd2);
              full = {(OP_CODE == OP_EXT_CODE_READ) ? r_reg.ext_page : 8'h00, p};
              PM_ADDR = full;
              PM_RE   = 1'b1;
              if (OP_MODE == PTR_POST_INC) begin
                full = full + `CDMB_ONE24;
                r_next.gpr[5'd30] = full[7:0];
                r_next.gpr[5'd31] = full[15:8];
                if (OP_CODE == OP_EXT_CODE_READ) begin
                  r_next.ext_page = full[23:16];
                end
              end
              r_next.dst   = OP_DST;
              r_next.state = ST_PM;
            end
            OP_CODE_WRITE: begin
              PM_ADDR  = {8'h00, ptr_get(r_reg.gpr, 2'd2)};
              PM_WE    = 1'b1;
              PM_WDATA = {r_reg.gpr[`CDMB_R1], r_reg.gpr[`CDMB_R0]};
            end
            OP_IN: begin
              IO_ADDR = OP_IMM[5:0];
              IO_RE   = 1'b1;
              r_next.gpr[OP_DST] = IO_RDATA;
            end
            OP_OUT: begin
              IO_ADDR  = OP_IMM[5:0];
              IO_WE    = 1'b1;
              IO_WDATA = r_reg.gpr[OP_SRC];
            end
            OP_PUSH: begin
              DM_ADDR      = r_reg.sp;
              DM_WE        = 1'b1;
              DM_WDATA     = r_reg.gpr[OP_SRC];
              r_next.sp    = r_reg.sp - `CDMB_ONE16;
              r_next.state = ST_WAIT;
            end
            OP_POP: begin
              r_next.sp    = r_reg.sp + `CDMB_ONE16;
              DM_ADDR      = r_next.sp;
              DM_RE        = 1'b1;
              r_next.dst   = OP_DST;
              r_next.state = ST_LOAD;
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              // read now, write back the merged byte next cycle
              IO_ADDR        = OP_IMM[5:0];
              IO_RE          = 1'b1;
              r_next.io_addr = OP_IMM[5:0];
              r_next.io_val  = IO_RDATA;
              r_next.bit_sel = OP_BIT;
              r_next.bit_set = (OP_CODE == OP_IO_BIT_SET);
              r_next.state   = ST_IO;
            end
            OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_SIGN_SHIFT_R: begin
              unique case (OP_CODE)
                OP_LSL: begin res = {d[6:0], 1'b0}; c = d[7]; end
                OP_LSR: begin res = {1'b0, d[7:1]}; c = d[0]; end
                OP_ROL: begin res = {d[6:0], r_reg.status_register[`CDMB_FLAG_C]}; c = d[7]; end
                OP_ROR: begin res = {r_reg.status_register[`CDMB_FLAG_C], d[7:1]}; c = d[0]; end
                default: begin res = {d[7], d[7:1]}; c = d[0]; end
              endcase
              r_next.gpr[OP_DST] = res;
              r_next.status_register        = shift_flags(r_reg.status_register, res, c);
            end
            OP_SWAP: r_next.gpr[OP_DST] = {d[3:0], d[7:4]};
            OP_STATUS_SET: r_next.status_register[OP_BIT] = 1'b1;
            OP_STATUS_CLR: r_next.status_register[OP_BIT] = 1'b0;
            OP_TO_TFLAG:   r_next.status_register[`CDMB_FLAG_T] = r_reg.gpr[OP_SRC][OP_BIT];
            OP_FROM_TFLAG: r_next.gpr[OP_DST][OP_BIT] = r_reg.status_register[`CDMB_FLAG_T];
            OP_IRQ_ON:  r_next.status_register[`CDMB_FLAG_I] = 1'b1;
            OP_IRQ_OFF: r_next.status_register[`CDMB_FLAG_I] = 1'b0;
            default: ;
          endcase
        end
      end
      ST_WAIT: r_next.state = ST_IDLE;
      ST_LOAD: begin
        r_next.gpr[r_reg.dst] = DM_RDATA;
        r_next.state          = ST_IDLE;
      end
      ST_PM: begin
        r_next.gpr[r_reg.dst] = PM_RDATA;
        r_next.state          = ST_WAIT;
      end
      ST_IO: begin
        IO_ADDR  = r_reg.io_addr;
        IO_WE    = 1'b1;
        IO_WDATA = r_reg.bit_set ? (r_reg.io_val | (8'h01 << r_reg.bit_sel))
                                 : (r_reg.io_val & ~(8'h01 << r_reg.bit_sel));
        r_next.state = ST_IDLE;
      end
      default: r_next.state = ST_IDLE;
    endcase

    // software access comes after execution, so its write wins a clash
    if (SW_WR) begin
      if (SW_ADDR <= `CDMB_SW_GPR_LAST) begin
        r_next.gpr[SW_ADDR[4:0]] = SW_WDATA;
      end else begin
        unique case (SW_ADDR)
          `CDMB_SW_STATUS:   r_next.status_register        = SW_WDATA;
          `CDMB_SW_EXT_PAGE: r_next.ext_page    = SW_WDATA;
          `CDMB_SW_PC_LO:    r_next.pc[7:0]     = SW_WDATA;
          `CDMB_SW_PC_HI:    r_next.pc[15:8]    = SW_WDATA;
          `CDMB_SW_SP_LO:    r_next.sp[7:0]     = SW_WDATA;
          `CDMB_SW_SP_HI:    r_next.sp[15:8]    = SW_WDATA;
          default: ;
        endcase
      end
    end
    if (SW_RD) begin
      if (SW_ADDR <= `CDMB_SW_GPR_LAST) begin
        r_next.sw_rdata = r_reg.gpr[SW_ADDR[4:0]];
      end else begin
        unique case (SW_ADDR)
          `CDMB_SW_STATUS:     r_next.sw_rdata = r_reg.status_register;
          `CDMB_SW_EXT_PAGE:   r_next.sw_rdata = r_reg.ext_page;
          `CDMB_SW_PC_LO:      r_next.sw_rdata = r_reg.pc[7:0];
          `CDMB_SW_PC_HI:      r_next.sw_rdata = r_reg.pc[15:8];
          `CDMB_SW_SP_LO:      r_next.sw_rdata = r_reg.sp[7:0];
          `CDMB_SW_SP_HI:      r_next.sw_rdata = r_reg.sp[15:8];
          `CDMB_SW_CORE_STATE: r_next.sw_rdata = {3'b000, r_reg.state};
          default:             r_next.sw_rdata = 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_reg          <= '0;
      r_reg.state    <= ST_IDLE;
      r_reg.status_register     <= `CDMB_STATUS_RST;
      r_reg.ext_page <= `CDMB_EXT_PAGE_RST;
      r_reg.pc       <= `CDMB_PC_RST;
      r_reg.sp       <= `CDMB_SP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign PC       = r_reg.pc;
  assign STATUS   = r_reg.status_register;
  assign SW_RDATA = r_reg.sw_rdata;

endmodule

/* verification/cdmb_core_chk.sv */
// concurrent checks on the data-move core ports
`timescale 1ns/1ps
module cdmb_core_chk (
  input wire logic               CORE_CLK,
  input wire logic               RESET_N,
  input wire logic               OP_VALID,
  input wire logic               OP_READY,
  input wire cdmb_pkg::cdmb_op_e OP_CODE,
  input wire logic [2:0]         OP_BIT,
  input wire logic [15:0]        OP_IMM,
  input wire logic [15:0]        DM_ADDR,
  input wire logic               DM_RE,
  input wire logic               DM_WE,
  input wire logic               PM_RE,
  input wire logic               PM_WE,
  input wire logic               IO_RE,
  input wire logic               IO_WE,
  input wire logic [7:0]         IO_WDATA,
  input wire logic [7:0]         IO_RDATA,
  input wire logic [15:0]        PC,
  input wire logic [7:0]         STATUS
);
  import cdmb_pkg::*;
  logic take;
  assign take = OP_VALID && OP_READY;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  // core busy for one cycle, then free again
  sequence s_busy_back;
    !OP_READY ##1 OP_READY;
  endsequence
  a_store_strobe_once: assert property (DM_WE |=> !DM_WE)
    else $error("data write strobe longer than one cycle");
  a_store_two_cycle: assert property (take && OP_CODE == OP_ST |-> DM_WE ##1 s_busy_back)
    else $error("indirect store not two cycles");
  a_load_two_cycle: assert property (take && OP_CODE == OP_LD |-> DM_RE ##1 s_busy_back)
    else $error("indirect load not two cycles");
  a_direct_load_addr: assert property (take && OP_CODE == OP_LOAD_DIRECT
    |-> DM_RE && DM_ADDR == OP_IMM)
    else $error("direct load address wrong");
  a_code_read_three: assert property (take && OP_CODE inside {OP_CODE_READ, OP_EXT_CODE_READ}
    |-> PM_RE ##1 !OP_READY ##1 s_busy_back)
    else $error("code read not three cycles");
  a_code_write_one: assert property (take && OP_CODE == OP_CODE_WRITE |-> PM_WE ##1 OP_READY)
    else $error("code write not one cycle");
  a_io_bit_merge: assert property (take && OP_CODE == OP_IO_BIT_SET |-> IO_RE ##1
    (IO_WE && IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(OP_BIT)))))
    else $error("io bit set disturbed other bits");
  a_branch_skip_one: assert property (take && OP_CODE inside {OP_BR_IRQ_ON, OP_BR_IRQ_OFF}
    && (STATUS[7] != (OP_CODE == OP_BR_IRQ_ON))
    |=> OP_READY && PC == $past(PC) + 16'h0001)
    else $error("untaken branch wrong");
  a_branch_jump_two: assert property (take && OP_CODE inside {OP_BR_IRQ_ON, OP_BR_IRQ_OFF}
    && (STATUS[7] == (OP_CODE == OP_BR_IRQ_ON)) |=> !OP_READY
    ##1 (OP_READY && PC == $past(PC, 2) + $past(OP_IMM, 2) + 16'h0001))
    else $error("taken branch wrong");
  a_copy_flags_kept: assert property (take && OP_CODE inside {OP_MOV, OP_COPY_PAIR, OP_SWAP}
    |=> STATUS == $past(STATUS))
    else $error("copy changed flags");
  a_irq_flag_follow: assert property (take && OP_CODE inside {OP_IRQ_ON, OP_IRQ_OFF}
    |=> STATUS[7] == ($past(OP_CODE) == OP_IRQ_ON))
    else $error("interrupt flag wrong");
endmodule

/* verification/cdmb_mem_model.sv */
// data, code and io memory model facing the core
`timescale 1ns/1ps
module cdmb_mem_model (
  input  wire logic        CORE_CLK,
  input  wire logic [15:0] DM_ADDR,
  input  wire logic        DM_RE,
  input  wire logic        DM_WE,
  input  wire logic [7:0]  DM_WDATA,
  output logic [7:0]       DM_RDATA,
  input  wire logic [23:0] PM_ADDR,
  input  wire logic        PM_RE,
  input  wire logic        PM_WE,
  input  wire logic [15:0] PM_WDATA,
  output logic [7:0]       PM_RDATA,
  input  wire logic [5:0]  IO_ADDR,
  input  wire logic        IO_RE,
  input  wire logic        IO_WE,
  input  wire logic [7:0]  IO_WDATA,
  output logic [7:0]       IO_RDATA
);
  // only the low address byte is decoded, so keep tests below 0x100
  logic [7:0]  dm [256];
  logic [7:0]  io [64];
  logic [15:0] pm_word;
  initial begin
    for (int i = 0; i < 256; i++) dm[i] = 8'(i) ^ 8'h5A;
    for (int i = 0; i < 64; i++) io[i] = 8'h18;
    pm_word = 16'h0000;
    DM_RDATA = 8'h00;
    PM_RDATA = 8'h00;
  end
  // read data live only the cycle after the strobe, toggling junk otherwise
  always @(posedge CORE_CLK) begin
    DM_RDATA <= DM_RE ? dm[DM_ADDR[7:0]] : ~DM_RDATA;
    PM_RDATA <= PM_RE ? (PM_ADDR[7:0] ^ PM_ADDR[23:16] ^ 8'hC3) : ~PM_RDATA;
    if (DM_WE) dm[DM_ADDR[7:0]] <= DM_WDATA;
    if (IO_WE) io[IO_ADDR] <= IO_WDATA;
    if (PM_WE) pm_word <= PM_WDATA;
  end
  assign IO_RDATA = IO_RE ? io[IO_ADDR] : ~io[IO_ADDR];
endmodule

/* verification/tb.sv */
// self-checking bench for the data-move core
`timescale 1ns/1ps
module tb;
  import cdmb_pkg::*;
  logic CORE_CLK, RESET_N, OP_VALID, OP_READY, SW_WR, SW_RD;
  logic DM_RE, DM_WE, PM_RE, PM_WE, IO_RE, IO_WE;
  logic [4:0] OP_DST, OP_SRC;
  logic [2:0] OP_BIT;
  logic [1:0] OP_PTR;
  logic [5:0] IO_ADDR;
  logic [7:0] DM_WDATA, DM_RDATA, PM_RDATA, IO_WDATA, IO_RDATA, STATUS;
  logic [7:0] SW_ADDR, SW_WDATA, SW_RDATA, e;
  logic [15:0] OP_IMM, DM_ADDR, PM_WDATA, PC;
  logic [23:0] PM_ADDR;
  cdmb_op_e OP_CODE;
  cdmb_ptr_mode_e OP_MODE;
  int failures, tests_run;
  cdmb_op_e sh_op [6] = '{OP_LSR, OP_LSL, OP_ROL, OP_ROR, OP_SIGN_SHIFT_R, OP_SWAP};
  logic [7:0] sh_in [6] = '{8'h81, 8'h80, 8'h40, 8'h01, 8'h81, 8'h3C};
  logic [7:0] sh_st [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h1F};
  logic [7:0] sh_res [6] = '{8'h40, 8'h00, 8'h81, 8'h80, 8'hC0, 8'hC3};
  logic [7:0] sh_flg [6] = '{8'h09, 8'h0B, 8'h0C, 8'h05, 8'h05, 8'h1F};

  cdmb_core dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID),
    .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_DST(OP_DST), .OP_SRC(OP_SRC), .OP_BIT(OP_BIT),
    .OP_PTR(OP_PTR), .OP_MODE(OP_MODE), .OP_IMM(OP_IMM), .DM_ADDR(DM_ADDR), .DM_RE(DM_RE),
    .DM_WE(DM_WE), .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA), .PM_ADDR(PM_ADDR), .PM_RE(PM_RE),
    .PM_WE(PM_WE), .PM_WDATA(PM_WDATA), .PM_RDATA(PM_RDATA), .IO_ADDR(IO_ADDR), .IO_RE(IO_RE),
    .IO_WE(IO_WE), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .PC(PC), .STATUS(STATUS),
    .SW_ADDR(SW_ADDR), .SW_WDATA(SW_WDATA), .SW_WR(SW_WR), .SW_RD(SW_RD), .SW_RDATA(SW_RDATA));
  cdmb_mem_model mem (.CORE_CLK(CORE_CLK), .DM_ADDR(DM_ADDR), .DM_RE(DM_RE), .DM_WE(DM_WE),
    .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA), .PM_ADDR(PM_ADDR), .PM_RE(PM_RE), .PM_WE(PM_WE),
    .PM_WDATA(PM_WDATA), .PM_RDATA(PM_RDATA), .IO_ADDR(IO_ADDR), .IO_RE(IO_RE), .IO_WE(IO_WE),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA));

  always #20 CORE_CLK = ~CORE_CLK;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    SW_ADDR <= a;
    SW_WDATA <= d;
    SW_WR <= 1'b1;
    @(posedge CORE_CLK);
    SW_WR <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    SW_ADDR <= a;
    SW_RD <= 1'b1;
    @(posedge CORE_CLK);
    SW_RD <= 1'b0;
    @(negedge CORE_CLK);
    chk(SW_RDATA, exp);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    @(negedge CORE_CLK);
    while (OP_READY !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        report_and_stop;
      end
      @(negedge CORE_CLK);
    end
  endtask
  task automatic op(input cdmb_op_e c, input logic [4:0] d, input logic [4:0] s,
                    input logic [2:0] b, input logic [1:0] p, input cdmb_ptr_mode_e m,
                    input logic [15:0] k);
    @(posedge CORE_CLK);
    OP_CODE <= c;
    OP_DST <= d;
    OP_SRC <= s;
    OP_BIT <= b;
    OP_PTR <= p;
    OP_MODE <= m;
    OP_IMM <= k;
    OP_VALID <= 1'b1;
    wait_ready;
    @(posedge CORE_CLK);
    OP_VALID <= 1'b0;
    wait_ready;
  endtask

  initial begin
    CORE_CLK = 1'b0;
    RESET_N = 1'b0;
    {OP_VALID, SW_WR, SW_RD, OP_DST, OP_SRC, OP_BIT, OP_PTR} = '0;
    {SW_ADDR, SW_WDATA, OP_IMM} = '0;
    OP_CODE = OP_NOP;
    OP_MODE = PTR_PLAIN;
    failures = 0;
    tests_run = 0;
    repeat (4) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h24, 8'hFF);
    rd(8'h25, 8'h0F);
    rd(8'h30, 8'h00);
    $display("test reset done");
    sw_wr(8'h1A, 8'h10);
    sw_wr(8'h1B, 8'h00);
    sw_wr(8'h1C, 8'h20);
    sw_wr(8'h1D, 8'h00);
    op(OP_LD, 5, 0, 0, 0, PTR_POST_INC, 0);
    op(OP_LD, 6, 0, 0, 0, PTR_PRE_DEC, 0);
    rd(8'h05, 8'h4A);
    rd(8'h06, 8'h4A);
    rd(8'h1A, 8'h10);
    op(OP_LD, 7, 0, 0, 1, PTR_DISP, 16'h0003);
    rd(8'h07, 8'h79);
    rd(8'h1C, 8'h20);
    op(OP_LOAD_DIRECT, 8, 0, 0, 0, PTR_PLAIN, 16'h0040);
    rd(8'h08, 8'h1A);
    rd(8'h22, 8'h05);
    $display("test loads done");
    sw_wr(8'h1E, 8'h30);
    sw_wr(8'h1F, 8'h00);
    op(OP_ST, 0, 5, 0, 2, PTR_PRE_DEC, 0);
    chk(mem.dm[8'h2F], 8'h4A);
    rd(8'h1E, 8'h2F);
    op(OP_ST, 0, 7, 0, 0, PTR_POST_INC, 0);
    chk(mem.dm[8'h10], 8'h79);
    rd(8'h1A, 8'h11);
    op(OP_ST, 0, 8, 0, 1, PTR_DISP, 16'h0005);
    chk(mem.dm[8'h25], 8'h1A);
    rd(8'h1C, 8'h20);
    op(OP_STORE_DIRECT, 0, 7, 0, 0, PTR_PLAIN, 16'h0050);
    chk(mem.dm[8'h50], 8'h79);
    $display("test stores done");
    sw_wr(8'h21, 8'h02);
    sw_wr(8'h1E, 8'hFF);
    sw_wr(8'h1F, 8'hFF);
    op(OP_EXT_CODE_READ, 11, 0, 0, 2, PTR_POST_INC, 0);
    rd(8'h0B, 8'h3E);
    rd(8'h1F, 8'h00);
    rd(8'h21, 8'h03);
    op(OP_CODE_READ, 0, 0, 0, 2, PTR_PLAIN, 0);
    rd(8'h00, 8'hC3);
    sw_wr(8'h01, 8'hAB);
    op(OP_CODE_WRITE, 0, 0, 0, 2, PTR_PLAIN, 0);
    chk(mem.pm_word[15:8], 8'hAB);
    chk(mem.pm_word[7:0], 8'hC3);
    $display("test code memory done");
    op(OP_PUSH, 0, 5, 0, 0, PTR_PLAIN, 0);
    chk(mem.dm[8'hFF], 8'h4A);
    rd(8'h24, 8'hFE);
    op(OP_POP, 12, 0, 0, 0, PTR_PLAIN, 0);
    rd(8'h0C, 8'h4A);
    rd(8'h24, 8'hFF);
    op(OP_IO_BIT_SET, 0, 0, 0, 0, PTR_PLAIN, 16'h0005);
    chk(mem.io[5], 8'h19);
    op(OP_IO_BIT_CLEAR, 0, 0, 3, 0, PTR_PLAIN, 16'h0005);
    chk(mem.io[5], 8'h11);
    op(OP_OUT, 0, 12, 0, 0, PTR_PLAIN, 16'h0006);
    chk(mem.io[6], 8'h4A);
    op(OP_IN, 13, 0, 0, 0, PTR_PLAIN, 16'h0006);
    rd(8'h0D, 8'h4A);
    op(OP_COPY_PAIR, 18, 4, 0, 0, PTR_PLAIN, 0);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h4A);
    op(OP_MOV, 15, 5, 0, 0, PTR_PLAIN, 0);
    rd(8'h0F, 8'h4A);
    $display("test stack, io and copies done");
    for (int i = 0; i < 6; i++) begin
      sw_wr(8'h0E, sh_in[i]);
      sw_wr(8'h20, sh_st[i]);
      op(sh_op[i], 14, 14, 0, 0, PTR_PLAIN, 0);
      rd(8'h0E, sh_res[i]);
      rd(8'h20, sh_flg[i]);
    end
    $display("test shifts done");
    sw_wr(8'h20, 8'h00);
    op(OP_TO_TFLAG, 0, 14, 6, 0, PTR_PLAIN, 0);
    rd(8'h20, 8'h40);
    op(OP_FROM_TFLAG, 20, 0, 4, 0, PTR_PLAIN, 0);
    rd(8'h14, 8'h10);
    rd(8'h20, 8'h40);
    e = 8'h40;
    for (int b = 0; b < 16; b++) begin
      op(b < 8 ? OP_STATUS_SET : OP_STATUS_CLR, 0, 0, 3'(b), 0, PTR_PLAIN, 0);
      e = (b < 8) ? (e | (8'h01 << b[2:0])) : (e & ~(8'h01 << b[2:0]));
      rd(8'h20, e);
    end
    op(OP_IRQ_ON, 0, 0, 0, 0, PTR_PLAIN, 0);
    rd(8'h20, 8'h80);
    sw_wr(8'h22, 8'h10);
    sw_wr(8'h23, 8'h00);
    op(OP_BR_IRQ_OFF, 0, 0, 0, 0, PTR_PLAIN, 16'h0005);
    op(OP_BR_IRQ_ON, 0, 0, 0, 0, PTR_PLAIN, 16'hFFFC);
    rd(8'h22, 8'h0E);
    rd(8'h23, 8'h00);
    op(OP_IRQ_OFF, 0, 0, 0, 0, PTR_PLAIN, 0);
    rd(8'h20, 8'h00);
    op(OP_BR_IRQ_OFF, 0, 0, 0, 0, PTR_PLAIN, 16'h0003);
    rd(8'h22, 8'h13);
    $display("test flags and branches done");
    report_and_stop;
  end
endmodule

bind cdmb_core cdmb_core_chk u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
  .OP_VALID(OP_VALID), .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_BIT(OP_BIT),
  .OP_IMM(OP_IMM), .DM_ADDR(DM_ADDR), .DM_RE(DM_RE), .DM_WE(DM_WE), .PM_RE(PM_RE),
  .PM_WE(PM_WE), .IO_RE(IO_RE), .IO_WE(IO_WE), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
  .PC(PC), .STATUS(STATUS));
